//--- core/ctwd_top.sv
// cycle-time watchdog with error code, error log and axi4-lite registers
`timescale 1ns/100ps
// What this block does
// - select picks default 1000 ms or user limit
// - user limit code 0001..0FA0 in 10 ms
// - overrun sets flag, fatal error, halts
// - extension adds operand times 10 ms, one cycle
// - extension above one second raises error flag
// - extensions accumulate until base plus extensions reaches 1000 ms; a base above 1000 ms gets none
// - at ceiling further extensions add no time
// - maximum cycle time kept, 32-bit binary
// - present cycle time kept, 32-bit binary
// - user fatal sets flag and error code
// - every fatal error logged with code and time, one entry per clock holding the worst code
// - error code word keeps most severe error
// - memory error writes 80F1 if worst, flag
// - fatal error lights indicator, stops operation
module ctwd_top #(
    parameter int unsigned TICK_CYCLES = ctwd_pkg::TICK_CYCLES_DEF
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    // axi4-lite slave
    input  wire logic [ctwd_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [ctwd_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // scan engine side
    input  wire logic                        cycle_start,
    input  wire logic                        cycle_extend_command,
    input  wire logic [15:0]                 cycle_extend_operand,
    input  wire logic                        fatal_error_command,
    input  wire logic [8:0]                  fatal_error_number,
    input  wire logic                        sys_error_valid,
    input  wire logic [15:0]                 sys_error_code,
    input  wire logic [31:0]                 time_date,
    output logic                             run_enable,
    output logic                             err_indicator,
    output logic                             instruction_error_flag,
    output logic                             irq
);
    import ctwd_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic                 limit_sel_r;
    logic [11:0]          user_code_r;
    logic [31:0]          tick_cnt_r;
    logic                 tick;
    logic [31:0]          run_ms_r, present_ms_r, max_ms_r, ext_ms_r;
    logic [31:0]          base_ms, limit_ms, req_ms, room_ms;
    logic                 halted_r;
    logic [15:0]          flags_r, err_code_r, new_code;
    logic                 ev_ovr, ev_user, ev_sys, ev_any, ev_instr;
    logic [IRQ_W-1:0]     irq_stat_r, irq_en_r, irq_set, irq_clr;
    logic [15:0]          log_code_r [LOG_DEPTH];
    logic [31:0]          log_time_r [LOG_DEPTH];
    logic [4:0]           log_ptr_r;
    logic [4:0]           log_cnt_r;
    // bus
    logic                 aw_got_r;
    logic                 w_got_r;
    logic [ADDR_W-1:0]    aw_addr_r;
    logic [31:0]          w_data_r;
    logic [3:0]           w_strb_r;
    logic                 wr_do;
    logic [31:0]          rd_data;
    logic                 rd_err;
    logic                 wr_err;
    logic [ADDR_W-1:0]    log_off;
    logic [4:0]           log_idx;

    // ------------------------------------------------------------------
    // millisecond time base
    // ------------------------------------------------------------------
    assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

    always_ff @(posedge clk_sys) begin
        if (rst || tick || cycle_start) begin
            tick_cnt_r <= 32'h0000_0000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // active limit
    // ------------------------------------------------------------------
    always_comb begin
        base_ms  = limit_sel_r ? 32'({20'h0, user_code_r}) * UNIT_MS
                               : DEF_LIMIT_MS;
        limit_ms = base_ms + ext_ms_r;
        req_ms   = 32'(cycle_extend_operand) * UNIT_MS;
        room_ms  = (limit_ms >= CEIL_MS) ? 32'h0000_0000
                                         : CEIL_MS - limit_ms;
    end

    // ------------------------------------------------------------------
    // cycle timing and extensions
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            run_ms_r     <= 32'h0000_0000;
            present_ms_r <= 32'h0000_0000;
            max_ms_r     <= 32'h0000_0000;
        end else if (!halted_r) begin
            if (cycle_start) begin
                run_ms_r     <= 32'h0000_0000;
                present_ms_r <= run_ms_r;
                if (run_ms_r > max_ms_r) begin
                    max_ms_r <= run_ms_r;
                end
            end else if (tick) begin
                run_ms_r <= run_ms_r + 32'h0000_0001;
            end
        end
    end

    // partial grants are trimmed to the room left under the ceiling
    always_ff @(posedge clk_sys) begin
        if (rst || cycle_start) begin
            ext_ms_r <= 32'h0000_0000;
        end else if (cycle_extend_command && !halted_r) begin
            if (req_ms > room_ms) begin
                ext_ms_r <= ext_ms_r + room_ms;
            end else begin
                ext_ms_r <= ext_ms_r + req_ms;
            end
        end
    end

    // operand range is the program's duty; the flag reports a violation
    assign ev_instr = (cycle_extend_command && req_ms > CEIL_MS)
                   || (fatal_error_command && fatal_error_number == 9'h000);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            instruction_error_flag <= 1'b0;
        end else if (cycle_extend_command || fatal_error_command) begin
            instruction_error_flag <= ev_instr;
        end
    end

    // ------------------------------------------------------------------
    // error events, severity and halt
    // ------------------------------------------------------------------
    assign ev_ovr  = !halted_r && (run_ms_r > limit_ms);
    assign ev_user = fatal_error_command
                  && (fatal_error_number != 9'h000);
    assign ev_sys  = sys_error_valid;
    assign ev_any  = ev_ovr || ev_user || ev_sys;

    // higher code means more serious; simultaneous events keep the worst
    always_comb begin
        new_code = 16'h0000;
        if (ev_ovr && ERR_OVERRUN > new_code) begin
            new_code = ERR_OVERRUN;
        end
        if (ev_user && (ERR_USER_BASE + 16'(fatal_error_number)) > new_code)
        begin
            new_code = ERR_USER_BASE + 16'(fatal_error_number);
        end
        if (ev_sys && sys_error_code > new_code) begin
            new_code = sys_error_code;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            err_code_r <= 16'h0000;
            flags_r    <= 16'h0000;
        end else if (ev_any) begin
            if (new_code > err_code_r) begin
                err_code_r <= new_code;
            end
            if (ev_ovr) begin
                flags_r[FLAG_OVERRUN] <= 1'b1;
            end
            if (ev_user) begin
                flags_r[FLAG_USER_FATAL] <= 1'b1;
            end
            if (ev_sys && sys_error_code == ERR_MEMORY) begin
                flags_r[FLAG_MEMORY] <= 1'b1;
            end
        end
    end

    // only reset clears a fatal stop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            halted_r      <= 1'b0;
            run_enable    <= 1'b0;
            err_indicator <= 1'b0;
        end else begin
            halted_r      <= halted_r || ev_any;
            run_enable    <= !(halted_r || ev_any);
            err_indicator <= halted_r || ev_any;
        end
    end

    // ------------------------------------------------------------------
    // error log, circular over the newest entries
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < LOG_DEPTH; i++) begin
                log_code_r[i] <= 16'h0000;
                log_time_r[i] <= 32'h0000_0000;
            end
            log_ptr_r <= 5'h00;
            log_cnt_r <= 5'h00;
        end else if (ev_any) begin
            log_code_r[log_ptr_r] <= new_code;
            log_time_r[log_ptr_r] <= time_date;
            log_ptr_r <= (log_ptr_r == 5'(LOG_DEPTH - 1))
                         ? 5'h00 : log_ptr_r + 5'h01;
            if (log_cnt_r != 5'(LOG_DEPTH)) begin
                log_cnt_r <= log_cnt_r + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupts: sticky status, set beats clear
    // ------------------------------------------------------------------
    always_comb begin
        irq_set              = '0;
        irq_set[IRQ_OVERRUN] = ev_ovr;
        irq_set[IRQ_USER]    = ev_user;
        irq_set[IRQ_SYS]     = ev_sys;
        irq_set[IRQ_INSTR]   = ev_instr;
        irq_clr = (wr_do && aw_addr_r == REG_IRQ_CLR && w_strb_r[0])
                  ? w_data_r[IRQ_W-1:0] : '0;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_stat_r <= '0;
            irq       <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            irq        <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    assign wr_do = aw_got_r && w_got_r && !s_axi_bvalid;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            aw_got_r      <= 1'b0;
            aw_addr_r     <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_got_r      <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
        end else if (wr_do) begin
            aw_got_r      <= 1'b0;
        end else if (!aw_got_r && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_wready <= 1'b0;
            w_got_r      <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_got_r      <= 1'b1;
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
        end else if (wr_do) begin
            w_got_r      <= 1'b0;
        end else if (!w_got_r && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_comb begin
        case (aw_addr_r)
            REG_CTRL, REG_USER_MAX, REG_IRQ_CLR, REG_IRQ_EN: wr_err = 1'b0;
            default: wr_err = 1'b1;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // out-of-range user codes are clamped into 0001..0FA0
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            limit_sel_r <= 1'b0;
            user_code_r <= USER_CODE_RST;
            irq_en_r    <= '0;
        end else if (wr_do) begin
            if (aw_addr_r == REG_CTRL && w_strb_r[0]) begin
                limit_sel_r <= w_data_r[0];
            end
            if (aw_addr_r == REG_USER_MAX && w_strb_r[1:0] == 2'h3) begin
                if (w_data_r[15:0] < 16'(USER_CODE_MIN)) begin
                    user_code_r <= USER_CODE_MIN;
                end else if (w_data_r[15:0] > 16'(USER_CODE_MAX)) begin
                    user_code_r <= USER_CODE_MAX;
                end else begin
                    user_code_r <= w_data_r[11:0];
                end
            end
            if (aw_addr_r == REG_IRQ_EN && w_strb_r[0]) begin
                irq_en_r <= w_data_r[IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    assign log_off = s_axi_araddr - REG_LOG_BASE;
    assign log_idx = log_off[7:3];

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (s_axi_araddr >= REG_LOG_BASE && s_axi_araddr < REG_LOG_END
            && s_axi_araddr[1:0] == 2'h0) begin
            rd_data = log_off[2] ? log_time_r[log_idx]
                                 : 32'(log_code_r[log_idx]);
        end else begin
            case (s_axi_araddr)
                REG_CTRL:       rd_data = 32'(limit_sel_r);
                REG_USER_MAX:   rd_data = 32'(user_code_r);
                REG_STATUS:     rd_data = 32'({instruction_error_flag,
                                               halted_r});
                REG_FLAGS:      rd_data = 32'(flags_r);
                REG_ERR_CODE:   rd_data = 32'(err_code_r);
                REG_MAX_CYCLE:  rd_data = max_ms_r;
                REG_PRES_CYCLE: rd_data = present_ms_r;
                REG_LIMIT:      rd_data = limit_ms;
                REG_IRQ_STAT:   rd_data = 32'(irq_stat_r);
                REG_IRQ_CLR:    rd_data = 32'h0000_0000;
                REG_IRQ_EN:     rd_data = 32'(irq_en_r);
                REG_LOG_INFO:   rd_data = 32'({log_cnt_r, 3'h0, log_ptr_r});
                default:        rd_err  = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule : ctwd_top

//--- pkg/ctwd_pkg.sv
// constants, offsets and codes of the cycle-time watchdog
package ctwd_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          TICK_TIME_MS    = 1;
    localparam int          TICK_CYCLES_DEF = TICK_TIME_MS * 1000000
                                              / CLK_PERIOD_NS;
    localparam logic [31:0] DEF_LIMIT_MS    = 32'h0000_03E8;
    localparam logic [31:0] CEIL_MS         = 32'h0000_03E8;
    localparam logic [31:0] UNIT_MS         = 32'h0000_000A;
    localparam logic [11:0] USER_CODE_MIN   = 12'h001;
    localparam logic [11:0] USER_CODE_MAX   = 12'hFA0;
    localparam logic [11:0] USER_CODE_RST   = 12'h064;

    // ------------------------------------------------------------------
    // error codes and flag bit positions
    // ------------------------------------------------------------------
    localparam logic [15:0] ERR_OVERRUN     = 16'h809F;
    localparam logic [15:0] ERR_MEMORY      = 16'h80F1;
    localparam logic [15:0] ERR_USER_BASE   = 16'hC100;
    localparam int          FLAG_USER_FATAL = 6;
    localparam int          FLAG_OVERRUN    = 8;
    localparam int          FLAG_MEMORY     = 15;

    // ------------------------------------------------------------------
    // interrupt bits
    // ------------------------------------------------------------------
    localparam int          IRQ_W           = 4;
    localparam int          IRQ_OVERRUN     = 0;
    localparam int          IRQ_USER        = 1;
    localparam int          IRQ_SYS         = 2;
    localparam int          IRQ_INSTR       = 3;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] REG_CTRL        = 12'h000;
    localparam logic [11:0] REG_USER_MAX    = 12'h004;
    localparam logic [11:0] REG_STATUS      = 12'h008;
    localparam logic [11:0] REG_FLAGS       = 12'h00C;
    localparam logic [11:0] REG_ERR_CODE    = 12'h010;
    localparam logic [11:0] REG_MAX_CYCLE   = 12'h014;
    localparam logic [11:0] REG_PRES_CYCLE  = 12'h018;
    localparam logic [11:0] REG_LIMIT       = 12'h01C;
    localparam logic [11:0] REG_IRQ_STAT    = 12'h020;
    localparam logic [11:0] REG_IRQ_CLR     = 12'h024;
    localparam logic [11:0] REG_IRQ_EN      = 12'h028;
    localparam logic [11:0] REG_LOG_INFO    = 12'h02C;
    localparam logic [11:0] REG_LOG_BASE    = 12'h100;
    localparam int          LOG_DEPTH       = 20;
    localparam logic [11:0] REG_LOG_END     = 12'h1A0;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : ctwd_pkg

//--- testbench/ctwd_asserts.sv
// port assertions for the cycle-time watchdog
`timescale 1ns/100ps
module ctwd_asserts (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        run_enable,
    input wire logic        err_indicator,
    input wire logic        instruction_error_flag,
    input wire logic        cycle_extend_command,
    input wire logic [15:0] cycle_extend_operand,
    input wire logic        fatal_error_command,
    input wire logic [8:0]  fatal_error_number,
    input wire logic        sys_error_valid,
    input wire logic [15:0] sys_error_code
);
    import ctwd_pkg::*;
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_stopped;
        !run_enable && err_indicator;
    endsequence
    sequence s_ext_ok;
        run_enable && cycle_extend_command && !fatal_error_command
            && cycle_extend_operand <= 16'h0064;
    endsequence
    a_user_fatal_stop: assert property (fatal_error_command
        && fatal_error_number != 9'h000 |=> s_stopped) else $error("no halt");
    a_mem_err_stop: assert property (sys_error_valid
        && sys_error_code == ERR_MEMORY |=> s_stopped) else $error("no halt");
    a_stop_sticky: assert property (s_stopped |=> s_stopped)
        else $error("halt released");
    a_ind_means_halt: assert property (err_indicator |-> !run_enable)
        else $error("running while indicator lit");
    a_ext_err_set: assert property (run_enable && cycle_extend_command
        && cycle_extend_operand > 16'h0064 |=> instruction_error_flag)
        else $error("flag not raised");
    a_ext_err_clr: assert property (s_ext_ok |=> !instruction_error_flag)
        else $error("flag not cleared");
    a_ext_err_hold: assert property (instruction_error_flag
        && !cycle_extend_command && !fatal_error_command
        |=> $stable(instruction_error_flag)) else $error("flag moved");
    a_zero_number: assert property (fatal_error_command
        && fatal_error_number == 9'h000 |=> instruction_error_flag)
        else $error("number zero accepted");
endmodule : ctwd_asserts

bind ctwd_top ctwd_asserts ctwd_asserts_inst (.*);

//--- testbench/cycle_time_watchdog_test.sv
// self-checking bench for the cycle-time watchdog
`timescale 1ns/100ps
module cycle_time_watchdog_test;
    import ctwd_pkg::*;
    // ------------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------------
    localparam int         T = 10;  // short ms tick keeps the run small
    localparam logic [3:0] START = 4'h8, EXT = 4'h4, FAT = 4'h2, SYS = 4'h1;
    logic        clk_sys = 1'b0, rst, s_axi_awvalid, s_axi_awready,
                 s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
                 s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
                 cycle_start, cycle_extend_command, fatal_error_command,
                 sys_error_valid, run_enable, err_indicator,
                 instruction_error_flag, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, time_date, rd_v;
    logic [15:0] cycle_extend_operand, sys_error_code;
    logic [8:0]  fatal_error_number;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, last_b, rd_r;
    int          err_total, checks_done, cyc;
    ctwd_top #(.TICK_CYCLES(T)) ctwd_top_inst (.*);
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        last_b = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_v = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask : rd
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk({30'h0, rd_r}, {30'h0, RESP_OKAY});
        chk(rd_v, e);
    endtask : rdchk
    // one strobe set per call, spaced so no strobe is driven twice at once
    task automatic fire(input logic [3:0] k, input logic [15:0] v);
        {cycle_start, cycle_extend_command, fatal_error_command,
         sys_error_valid} <= k;
        cycle_extend_operand <= v;
        fatal_error_number   <= v[8:0];
        sys_error_code       <= v;
        @(posedge clk_sys);
        {cycle_start, cycle_extend_command, fatal_error_command,
         sys_error_valid} <= 4'h0;
        @(posedge clk_sys);
    endtask : fire
    task automatic do_reset;
        rst <= 1'b1;
        tick(12);
        rst <= 1'b0;
        tick(1);
    endtask : do_reset
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic test_regs;
        rdchk(REG_CTRL, 32'h0);
        rdchk(REG_USER_MAX, 32'h0000_0064);
        rdchk(REG_LIMIT, DEF_LIMIT_MS);
        rdchk(REG_IRQ_CLR, 32'h0);
        rd(12'h030);
        chk({30'h0, rd_r}, {30'h0, RESP_SLVERR});
        wr(REG_STATUS, 32'h0000_0003);
        chk({30'h0, last_b}, {30'h0, RESP_SLVERR});
    endtask : test_regs
    task automatic test_times;
        wr(REG_CTRL, 32'h0000_0001);
        wr(REG_USER_MAX, 32'h0000_0005);
        rdchk(REG_LIMIT, 32'h0000_0032);
        fire(START, 16'h0);
        tick(30 * T + 3);
        fire(START, 16'h0);
        tick(20 * T + 3);
        fire(START, 16'h0);
        rdchk(REG_PRES_CYCLE, 32'h0000_0014);
        rdchk(REG_MAX_CYCLE, 32'h0000_001E);
    endtask : test_times
    task automatic test_extend;
        wr(REG_USER_MAX, 32'h0000_0032);
        fire(START, 16'h0);
        fire(EXT, 16'h001E);
        rdchk(REG_LIMIT, 32'h0000_0320);
        fire(EXT, 16'h0032);
        rdchk(REG_LIMIT, CEIL_MS);
        fire(EXT, 16'h0001);
        rdchk(REG_LIMIT, CEIL_MS);
        chk({31'h0, instruction_error_flag}, 32'h0);
        fire(EXT, 16'h0065);
        chk({31'h0, instruction_error_flag}, 32'h1);
        fire(EXT, 16'h0000);
        chk({31'h0, instruction_error_flag}, 32'h0);
        wr(REG_USER_MAX, 32'h0000_0005);
        fire(START, 16'h0);
        rdchk(REG_LIMIT, 32'h0000_0032);
        fire(EXT, 16'h000A);
        tick(120 * T);
        chk({31'h0, run_enable}, 32'h1);
    endtask : test_extend
    task automatic test_overrun;
        fire(START, 16'h0);
        tick(70 * T);
        chk({30'h0, run_enable, err_indicator}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rdchk(REG_FLAGS, 32'h0000_0100);
        rdchk(REG_ERR_CODE, {16'h0, ERR_OVERRUN});
        rdchk(REG_IRQ_STAT, 32'h0000_0009);
        wr(REG_IRQ_EN, 32'h0000_0001);
        tick(2);
        chk({31'h0, irq}, 32'h1);
        wr(REG_IRQ_CLR, 32'h0000_000F);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        rdchk(REG_IRQ_STAT, 32'h0);
    endtask : test_overrun
    task automatic test_errors;
        do_reset();
        time_date <= 32'h0001_0203;
        fire(SYS, ERR_MEMORY);
        rdchk(REG_ERR_CODE, {16'h0, ERR_MEMORY});
        rdchk(REG_FLAGS, 32'h0000_8000);
        chk({30'h0, run_enable, err_indicator}, 32'h1);
        time_date <= 32'h0A0B_0C0D;
        fire(FAT, 16'h001F);
        rdchk(REG_ERR_CODE, 32'h0000_C11F);
        rdchk(REG_FLAGS, 32'h0000_8040);
        fire(SYS, ERR_MEMORY);
        rdchk(REG_ERR_CODE, 32'h0000_C11F);
        rdchk(REG_LOG_BASE + 12'h008, 32'h0000_C11F);
        rdchk(REG_LOG_BASE + 12'h00C, 32'h0A0B_0C0D);
        rdchk(REG_LOG_INFO, 32'h0000_0303);
        fire(FAT, 16'h0000);
        chk({31'h0, instruction_error_flag}, 32'h1);
    endtask : test_errors
    task automatic final_report;
        $display("checks %0d, errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
         s_axi_rready, cycle_start, cycle_extend_command,
         fatal_error_command, sys_error_valid} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, time_date,
         cycle_extend_operand, sys_error_code, fatal_error_number} = '0;
        s_axi_wstrb = 4'hF;
        do_reset();
        test_regs();
        test_times();
        test_extend();
        test_overrun();
        test_errors();
        final_report();
    end
endmodule : cycle_time_watchdog_test
